// file: pkg/ufmt_map.svh
// Purpose: Register offsets, field positions, reset values of the USART tx
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes: Included by bare name
`ifndef UFMT_MAP_SVH
`define UFMT_MAP_SVH
// ==========================================================
// Offsets
`define UFMT_OFF_DATA 4'h0
`define UFMT_OFF_CSA 4'h4
`define UFMT_OFF_CSB 4'h8
`define UFMT_OFF_FRM 4'hc
`define UFMT_OFF_BAUDL 4'h0
// ==========================================================
// Field positions
`define UFMT_CSA_DONE 6
`define UFMT_CSA_EMPTY 5
`define UFMT_CSA_FERR 4
`define UFMT_CSA_DBL 1
`define UFMT_CSB_TX_ENABLE_BIT 3
`define UFMT_CSB_SIZE2 2
`define UFMT_CSB_NINTH 0
`define UFMT_FRM_SEL 7
`define UFMT_FRM_SYNC 6
`define UFMT_FRM_PAR_HI 5
`define UFMT_FRM_PAR_LO 4
`define UFMT_FRM_STOP 3
`define UFMT_FRM_SIZE_HI 2
`define UFMT_FRM_SIZE_LO 1
// ==========================================================
// Reset values
`define UFMT_RST_FRM 8'h06
`define UFMT_RST_BAUD 12'h000
// Reset format fields: eight data bits, no parity, one stop
`define UFMT_RST_SIZE 3'h3
`define UFMT_RST_PAR 2'h0
`define UFMT_RST_STOP 1'b0
`endif

// file: pkg/ufmt_pkg.sv
// Purpose: Types shared by the USART transmit frame formatter
// Assumes: Nothing
// Notes: Constants live in ufmt_map.svh
package ufmt_pkg;
   // ==========================================================
   // Frame format
   typedef struct packed {
      logic [2:0] size;
      logic [1:0] parity;
      logic stop2;
   } ufmt_fmt_t;
   typedef enum logic [1:0] {
      UFMT_BIT_START,
      UFMT_BIT_DATA,
      UFMT_BIT_PARITY,
      UFMT_BIT_STOP
   } ufmt_phase_t;
endpackage

// file: verilog/ufmt_tick.sv
// Purpose: Bit-rate tick for the transmitter
// Assumes: Divider value and mode from registers; ext clock synchronised
// Notes: Internal: fosc/(div+1)/16 or /8; sync: edge of ext clock
`timescale 1ns/1ps
module ufmt_tick (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [11:0] i_div,
   input wire logic i_div_load,
   input wire logic i_dbl,
   input wire logic i_sync,
   input wire logic i_xck,
   output logic o_tick
);
   logic [11:0] cnt_reg;
   logic [3:0] pre_reg;
   logic x1_reg;
   logic x2_reg;
   logic x3_reg;
   logic base;
   assign base = (cnt_reg == 12'h000);
   // ==========================================================
   // Down-counter, reloaded on zero or divider low write
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || i_div_load || base) begin
         cnt_reg <= i_div;
      end else begin
         cnt_reg <= cnt_reg - 12'h001;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pre_reg <= 4'h0;
      end else if (base) begin
         pre_reg <= pre_reg + 4'h1;
      end
   end
   // ==========================================================
   // Ext clock: x2 and x3 feed the rising-edge detector
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         x1_reg <= 1'b0;
         x2_reg <= 1'b0;
         x3_reg <= 1'b0;
      end else begin
         x1_reg <= i_xck;
         x2_reg <= x1_reg;
         x3_reg <= x2_reg;
      end
   end
   always_comb begin
      if (i_sync) begin
         o_tick = x2_reg && !x3_reg;
      end else if (i_dbl) begin
         o_tick = base && (pre_reg[2:0] == 3'h7);
      end else begin
         o_tick = base && (pre_reg == 4'hf);
      end
   end
endmodule

// file: verilog/ufmt_shift.sv
// Purpose: Transmit shift register, one bit per tick
// Assumes: Format stable while busy
// Notes: Line idles high
`timescale 1ns/1ps
module ufmt_shift (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_tick,
   input wire logic i_load,
   input wire logic [8:0] i_data,
   input wire ufmt_pkg::ufmt_fmt_t i_fmt,
   output logic o_idle,
   output logic o_last,
   output logic o_line
);
   ufmt_pkg::ufmt_phase_t ph_reg;
   logic busy_reg;
   logic [8:0] sh_reg;
   logic [3:0] n_reg;
   logic par_reg;
   logic line_reg;
   logic [3:0] nbits;
   logic [8:0] mask;
   assign nbits = (i_fmt.size == 3'h7) ? 4'h9 : {2'b00, i_fmt.size[1:0]} + 4'h5;
   assign mask = (9'h1ff >> (4'h9 - nbits));
   assign o_idle = !busy_reg;
   assign o_line = line_reg;
   assign o_last = busy_reg && i_tick && (ph_reg == ufmt_pkg::UFMT_BIT_STOP)
      && (n_reg == 4'h0);
   // ==========================================================
   // Frame sequencer
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         busy_reg <= 1'b0;
         ph_reg <= ufmt_pkg::UFMT_BIT_START;
         sh_reg <= 9'h000;
         n_reg <= 4'h0;
         par_reg <= 1'b0;
         line_reg <= 1'b1;
      end else if (i_load) begin
         busy_reg <= 1'b1;
         ph_reg <= ufmt_pkg::UFMT_BIT_START;
         sh_reg <= i_data & mask;
         par_reg <= ^(i_data & mask) ^ i_fmt.parity[0];
         n_reg <= nbits - 4'h1;
      end else if (busy_reg && i_tick) begin
         unique case (ph_reg)
            ufmt_pkg::UFMT_BIT_START: begin
               line_reg <= 1'b0;
               ph_reg <= ufmt_pkg::UFMT_BIT_DATA;
            end
            ufmt_pkg::UFMT_BIT_DATA: begin
               line_reg <= sh_reg[0];
               sh_reg <= {1'b0, sh_reg[8:1]};
               if (n_reg == 4'h0) begin
                  // One extra count so the last stop bit is fully sent
                  n_reg <= i_fmt.stop2 ? 4'h2 : 4'h1;
                  ph_reg <= i_fmt.parity[1] ? ufmt_pkg::UFMT_BIT_PARITY
                     : ufmt_pkg::UFMT_BIT_STOP;
               end else begin
                  n_reg <= n_reg - 4'h1;
               end
            end
            ufmt_pkg::UFMT_BIT_PARITY: begin
               line_reg <= par_reg;
               ph_reg <= ufmt_pkg::UFMT_BIT_STOP;
            end
            ufmt_pkg::UFMT_BIT_STOP: begin
               line_reg <= 1'b1;
               if (n_reg == 4'h0) begin
                  busy_reg <= 1'b0;
               end else begin
                  n_reg <= n_reg - 4'h1;
               end
            end
         endcase
      end else if (!busy_reg && i_tick) begin
         line_reg <= 1'b1;
      end
   end
endmodule

// file: verilog/ufmt_top.sv
// Purpose: USART frame formatter and transmitter with Avalon-MM registers
// Assumes: 20 MHz clock, synchronous reset, one waitrequest cycle per access
// Notes: Receiver limited to first-stop-bit framing check on a line input
// ==========================================================
// Behaviour
// - Thirty formats: 5-9 bits, parity, stops
// - Start first, then data LSB first
// - Parity after last data, before stop
// - Back-to-back frames or idle high line
// - Start bit low, stop bits high
// - One format shared by tx and rx
// - Rx checks first stop only for framing
// - Parity is data xor, inverted if odd
// - Tx enable takes over the output pin
// - Sync mode clocks from external pin
// - Data register write starts transmission
// - Load shifter when idle or after stop
// - Shift at baud rate or external clock
// - Unused high data bits are ignored
// - Select bit routes shared write to format
// - Ninth data bit carried unchanged
// - Buffer-empty set when empty, cleared on write
// - Done flag set when all sent, write-one clears
// - Disable waits until shifter and buffer empty
// - Upper parity bit enables parity
`timescale 1ns/1ps
`include "ufmt_map.svh"
module ufmt_top (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_xck,
   input wire logic i_rx_line,
   input wire logic i_port_out,
   output logic o_txd,
   output logic o_txd_oe
);
   logic ack_reg;
   logic [31:0] rd_reg;
   logic [7:0] data_reg;
   logic ninth_reg;
   logic buf_full_reg;
   logic done_reg;
   logic dbl_reg;
   logic tx_enable_bit_reg;
   logic tx_on_reg;
   logic sync_reg;
   logic [11:0] baud_reg;
   ufmt_pkg::ufmt_fmt_t fmt_reg;
   logic ferr_reg;
   logic wr;
   logic rd;
   logic wr_data;
   logic wr_baudl;
   logic sh_idle;
   logic sh_last;
   logic sh_line;
   logic tick;
   logic load;
   logic r1_reg;
   logic r2_reg;
   logic r3_reg;
   logic [3:0] rcnt_reg;
   logic [3:0] rstop_reg;
   logic rbusy_reg;

   // ==========================================================
   // Bus slave: one wait cycle, then ack
   assign wr = i_avs_write && !ack_reg;
   assign rd = i_avs_read && !ack_reg;
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
   assign wr_data = i_avs_write && ack_reg
      && (i_avs_address == `UFMT_OFF_DATA) && i_avs_byteenable[0];
   assign wr_baudl = i_avs_write && ack_reg
      && (i_avs_address == `UFMT_OFF_BAUDL) && i_avs_byteenable[1];
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (wr || rd);
      end
   end
   // Read data frozen in the wait cycle
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rd_reg <= 32'h0000_0000;
      end else if (rd) begin
         unique case (i_avs_address)
            `UFMT_OFF_DATA: rd_reg <= {16'h0000, baud_reg[7:0], 8'h00};
            `UFMT_OFF_CSA: rd_reg <= {24'h000000, 1'b0, done_reg,
               !buf_full_reg, ferr_reg, 2'b00, dbl_reg, 1'b0};
            `UFMT_OFF_CSB: rd_reg <= {28'h0000000, tx_enable_bit_reg,
               fmt_reg.size[2], 1'b0, ninth_reg};
            `UFMT_OFF_FRM: rd_reg <= {24'h000000, 1'b1, sync_reg,
               fmt_reg.parity, fmt_reg.stop2, fmt_reg.size[1:0], 1'b0};
            default: rd_reg <= 32'h0000_0000;
         endcase
      end
   end
   assign o_avs_readdata = rd_reg;

   // ==========================================================
   // Data word: bits 7:0 data, bits 15:8 baud low
   // Baud high and format share one offset; bit 7 selects
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         baud_reg <= `UFMT_RST_BAUD;
         fmt_reg.size <= `UFMT_RST_SIZE;
         fmt_reg.parity <= `UFMT_RST_PAR;
         fmt_reg.stop2 <= `UFMT_RST_STOP;
         sync_reg <= 1'b0;
      end else if (i_avs_write && ack_reg) begin
         if (wr_baudl) begin
            baud_reg[7:0] <= i_avs_writedata[15:8];
         end
         if ((i_avs_address == `UFMT_OFF_FRM) && i_avs_byteenable[0]) begin
            if (i_avs_writedata[`UFMT_FRM_SEL]) begin
               sync_reg <= i_avs_writedata[`UFMT_FRM_SYNC];
               fmt_reg.parity <= i_avs_writedata[`UFMT_FRM_PAR_HI:
                  `UFMT_FRM_PAR_LO];
               fmt_reg.stop2 <= i_avs_writedata[`UFMT_FRM_STOP];
               fmt_reg.size[1:0] <= i_avs_writedata[`UFMT_FRM_SIZE_HI:
                  `UFMT_FRM_SIZE_LO];
            end else begin
               baud_reg[11:8] <= i_avs_writedata[3:0];
            end
         end
         if ((i_avs_address == `UFMT_OFF_CSB) && i_avs_byteenable[0]) begin
            fmt_reg.size[2] <= i_avs_writedata[`UFMT_CSB_SIZE2];
         end
      end
   end
   // ==========================================================
   // Control B and A
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         tx_enable_bit_reg <= 1'b0;
         ninth_reg <= 1'b0;
         dbl_reg <= 1'b0;
      end else if (i_avs_write && ack_reg && i_avs_byteenable[0]) begin
         if (i_avs_address == `UFMT_OFF_CSB) begin
            tx_enable_bit_reg <= i_avs_writedata[`UFMT_CSB_TX_ENABLE_BIT];
            ninth_reg <= i_avs_writedata[`UFMT_CSB_NINTH];
         end
         if (i_avs_address == `UFMT_OFF_CSA) begin
            dbl_reg <= i_avs_writedata[`UFMT_CSA_DBL];
         end
      end
   end

   // ==========================================================
   // Transmit buffer
   assign load = buf_full_reg && tx_on_reg && (sh_idle || sh_last);
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         data_reg <= 8'h00;
         buf_full_reg <= 1'b0;
      end else if (wr_data) begin
         data_reg <= i_avs_writedata[7:0];
         buf_full_reg <= 1'b1;
      end else if (load) begin
         buf_full_reg <= 1'b0;
      end
   end
   // Done flag: set beats write-one clear
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         done_reg <= 1'b0;
      end else if (sh_last && !buf_full_reg) begin
         done_reg <= 1'b1;
      end else if (i_avs_write && ack_reg && i_avs_byteenable[0]
         && (i_avs_address == `UFMT_OFF_CSA)
         && i_avs_writedata[`UFMT_CSA_DONE]) begin
         done_reg <= 1'b0;
      end
   end
   // Pin ownership outlives the enable until drained
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         tx_on_reg <= 1'b0;
      end else if (tx_enable_bit_reg) begin
         tx_on_reg <= 1'b1;
      end else if (sh_idle && !buf_full_reg) begin
         tx_on_reg <= 1'b0;
      end
   end
   assign o_txd = tx_on_reg ? sh_line : i_port_out;
   assign o_txd_oe = 1'b1;

   // ==========================================================
   // Datapath
   ufmt_tick u_tick (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_div(baud_reg),
      .i_div_load(wr_baudl),
      .i_dbl(dbl_reg),
      .i_sync(sync_reg),
      .i_xck(i_xck),
      .o_tick(tick)
   );
   ufmt_shift u_shift (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_tick(tick),
      .i_load(load),
      .i_data({ninth_reg, data_reg}),
      .i_fmt(fmt_reg),
      .o_idle(sh_idle),
      .o_last(sh_last),
      .o_line(sh_line)
   );

   // ==========================================================
   // Rx framing check, one sample per tick; no recovery
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         r1_reg <= 1'b1;
         r2_reg <= 1'b1;
      end else begin
         r1_reg <= i_rx_line;
         r2_reg <= r1_reg;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         r3_reg <= 1'b1;
         rbusy_reg <= 1'b0;
         rcnt_reg <= 4'h0;
         rstop_reg <= 4'h0;
         ferr_reg <= 1'b0;
      end else if (tick) begin
         r3_reg <= r2_reg;
         if (!rbusy_reg && !r2_reg) begin
            rbusy_reg <= 1'b1;
            rcnt_reg <= 4'h0;
            rstop_reg <= ((fmt_reg.size == 3'h7) ? 4'h9
               : {2'b00, fmt_reg.size[1:0]} + 4'h5)
               + {3'b000, fmt_reg.parity[1]} + 4'h1;
         end else if (rbusy_reg) begin
            rcnt_reg <= rcnt_reg + 4'h1;
            if (rcnt_reg == rstop_reg - 4'h1) begin
               rbusy_reg <= 1'b0;
               ferr_reg <= !r2_reg;
            end
         end
      end
   end
endmodule

// file: tb/ufmt_top_monitor.sv
// Purpose: Port checker for ufmt_top
// Assumes: Async mode, no double speed, so a bit lasts 16 clocks or more
// Notes: Bound to every ufmt_top instance below
`timescale 1ns/1ps
module ufmt_top_monitor (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic i_port_out,
   input wire logic o_txd,
   input wire logic o_txd_oe
);
   // ======
   // Shadow of the enable bit
   logic req;
   logic fin;
   logic tx_enable_bit_reg;
   assign req = i_avs_read | i_avs_write;
   assign fin = req & ~o_avs_waitrequest;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         tx_enable_bit_reg <= 1'b0;
      end else if (fin && i_avs_write && i_avs_address == 4'h8) begin
         tx_enable_bit_reg <= i_avs_writedata[3];
      end
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   // ======
   // Properties
   property p_wait_first;
      req && !$past(req) |-> o_avs_waitrequest;
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait");
   property p_wait_done;
      req && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   a_wait_done: assert property (p_wait_done) else $error("stuck");
   property p_no_req;
      !req |-> !o_avs_waitrequest;
   endproperty
   a_no_req: assert property (p_no_req) else $error("idle wait");
   property p_oe;
      o_txd_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("pin not driven");
   property p_port;
      $past(i_sys_rst) |-> o_txd == i_port_out;
   endproperty
   a_port: assert property (p_port) else $error("port not shown");
   property p_frm;
      fin && i_avs_read && i_avs_address == 4'hc |-> o_avs_readdata[7];
   endproperty
   a_frm: assert property (p_frm) else $error("select bit low");
   property p_unmap;
      fin && i_avs_read && i_avs_address[1:0] != 2'b00
         |-> o_avs_readdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped data");
   // Short bits would mean a wrong tick source
   property p_bit_min;
      tx_enable_bit_reg && $changed(o_txd) |=> $stable(o_txd) [*8];
   endproperty
   a_bit_min: assert property (p_bit_min) else $error("bit short");
   c_data: cover property (fin && i_avs_write && i_avs_address == 4'h0);
   c_start: cover property (tx_enable_bit_reg && $fell(o_txd));
   c_frm: cover property (fin && i_avs_read && i_avs_address == 4'hc);
endmodule
bind ufmt_top ufmt_top_monitor i_mon (.i_clk, .i_sys_rst, .i_avs_address,
   .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
   .o_avs_waitrequest, .i_port_out, .o_txd, .o_txd_oe);

// file: tb/ufmt_remote.sv
// Purpose: Remote receiver model on the serial line
// Assumes: Fixed clocks per bit
// Notes: Echoes the line back as the remote input
`timescale 1ns/1ps
module ufmt_remote #(
   parameter int BITP = 16
) (
   input wire logic i_clk,
   input wire logic i_line,
   input wire logic i_en,
   input wire logic [3:0] i_nbits,
   input wire logic i_par_en,
   input wire logic i_stop2,
   output logic o_rx_line,
   output logic [8:0] o_data,
   output logic o_par,
   output logic [1:0] o_stops,
   output logic [7:0] o_frames
);
   int i;
   assign o_rx_line = i_line;
   initial begin
      o_data = 9'h000;
      o_par = 1'b0;
      o_stops = 2'b00;
      o_frames = 8'h00;
      forever begin
         @(posedge i_clk);
         if (i_en && i_line === 1'b0) begin
            repeat (BITP / 2) @(posedge i_clk);
            o_data = 9'h000;
            for (i = 0; i < i_nbits; i++) begin
               repeat (BITP) @(posedge i_clk);
               o_data[i] = i_line;
            end
            if (i_par_en) begin
               repeat (BITP) @(posedge i_clk);
               o_par = i_line;
            end
            repeat (BITP) @(posedge i_clk);
            o_stops = {1'b1, i_line};
            if (i_stop2) begin
               repeat (BITP) @(posedge i_clk);
               o_stops[1] = i_line;
            end
            o_frames = o_frames + 8'h01;
         end
      end
   end
endmodule

// file: tb/ufmt_tb_top.sv
// Purpose: Self-checking bench for ufmt_top
// Assumes: Baud divider 0, 16 clocks per bit
// Notes: Row table, then hand tests
`timescale 1ns/1ps
module ufmt_tb_top;
   typedef struct packed {
      logic [2:0] size;
      logic [1:0] par;
      logic stop2;
      logic [8:0] data;
      logic [8:0] exp;
   } ufmt_row_t;
   ufmt_row_t rows [8] = '{'{3'h0, 2'b00, 1'b0, 9'h0ff, 9'h01f},
      '{3'h1, 2'b10, 1'b1, 9'h02d, 9'h02d},
      '{3'h2, 2'b11, 1'b0, 9'h055, 9'h055},
      '{3'h3, 2'b10, 1'b0, 9'h0a5, 9'h0a5},
      '{3'h3, 2'b11, 1'b1, 9'h000, 9'h000},
      '{3'h7, 2'b11, 1'b0, 9'h1a5, 9'h1a5},
      '{3'h7, 2'b10, 1'b1, 9'h101, 9'h101},
      '{3'h0, 2'b11, 1'b1, 9'h0ea, 9'h00a}};
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic rd = 1'b0;
   logic we = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic port = 1'b1;
   logic en = 1'b0;
   logic [3:0] nb = 4'h8;
   logic pe = 1'b0;
   logic s2 = 1'b0;
   logic [31:0] rdata;
   logic wait_n;
   logic txd;
   logic rxl;
   logic [8:0] data;
   logic par;
   logic [1:0] stops;
   logic [7:0] frames;
   logic [31:0] q;
   ufmt_row_t row;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   always #25 i_clk = ~i_clk;
   ufmt_top i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(we),
      .i_avs_writedata(wdata), .i_avs_byteenable(4'h1),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wait_n),
      .i_xck(1'b0), .i_rx_line(rxl), .i_port_out(port), .o_txd(txd),
      .o_txd_oe());
   ufmt_remote i_rem (.i_clk(i_clk), .i_line(txd), .i_en(en),
      .i_nbits(nb), .i_par_en(pe), .i_stop2(s2), .o_rx_line(rxl),
      .o_data(data), .o_par(par), .o_stops(stops), .o_frames(frames));
   // ======
   // Bus, check and closing tasks
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
      @(posedge i_clk);
      rd <= ~wr;
      we <= wr;
      addr <= a;
      wdata <= d;
      @(posedge i_clk);
      while (wait_n !== 1'b0) @(posedge i_clk);
      q = rdata;
      rd <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_frames(input logic [7:0] k);
      while (frames !== k) @(posedge i_clk);
   endtask
   task automatic end_of_test();
      $display("errors %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Ceiling is about ten times the expected run
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   // ======
   // Main sequence
   initial begin
      repeat (10) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      bus(1'b0, 4'h4, 32'h0);
      chk(q[6:5], 2'b01);
      bus(1'b0, 4'hc, 32'h0);
      chk(q[7:0], 8'h86);
      en = 1'b1;
      for (int r = 0; r < 8; r++) begin
         row = rows[r];
         nb = (row.size == 3'h7) ? 4'h9 : {1'b0, row.size} + 4'h5;
         pe = row.par[1];
         s2 = row.stop2;
         bus(1'b1, 4'hc, {24'h0, 2'b10, row.par, row.stop2, row.size[1:0],
            1'b0});
         bus(1'b1, 4'h8, {28'h0, 1'b1, row.size[2], 1'b0, row.data[8]});
         bus(1'b1, 4'h4, 32'h40);
         bus(1'b1, 4'h0, {23'h0, row.data});
         wait_frames(frames + 8'h01);
         chk(data, row.exp);
         if (pe) chk(par, ^row.exp ^ row.par[0]);
         chk(stops, 2'b11);
         // Done rises only once the last stop bit has ended
         repeat (24) @(posedge i_clk);
         bus(1'b0, 4'h4, 32'h0);
         chk(q[6:4], 3'b110);
      end
      // Back to back, then disable mid-frame
      nb = 4'h8;
      pe = 1'b0;
      s2 = 1'b0;
      bus(1'b1, 4'hc, 32'h86);
      bus(1'b1, 4'h8, 32'h8);
      bus(1'b1, 4'h0, 32'h3c);
      bus(1'b1, 4'h0, 32'hc3);
      bus(1'b0, 4'h4, 32'h0);
      chk(q[5], 1'b0);
      bus(1'b1, 4'h8, 32'h0);
      port <= 1'b0;
      wait_frames(frames + 8'h01);
      chk(data, 9'h03c);
      wait_frames(frames + 8'h01);
      chk(data, 9'h0c3);
      en = 1'b0;
      repeat (20) @(posedge i_clk);
      chk(txd, 1'b0);
      bus(1'b0, 4'h2, 32'h0);
      chk(q, 32'h0);
      // Second reset mid-run
      port <= 1'b1;
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      bus(1'b0, 4'h8, 32'h0);
      chk(q[3], 1'b0);
      bus(1'b0, 4'hc, 32'h0);
      chk(q[7:0], 8'h86);
      end_of_test();
   end
endmodule
